// ===== ags_selector.sv
// Behaviour
// (R1) Group comes from switches or host command.
// (R2) Exactly one source active, fixed by configuration.
// (R3) Four switch inputs encode sixteen groups.
// (R4) Group equals switch value plus one.
// (R5) Frames start AA8888AA, end 88AAAA88.
// (R6) Bytes 6-9 hold frame length, MSB first.
// (R7) Set command: E3 13, group, zero check.
// (R8) Set command is always answered; malformed frames get no reply, only a cmd_error pulse, except a broken header, which is dropped with no pulse.
// (R9) Set reply F3 13, status 00/01.
// (R10) Set reply check zero, trailer 12-15.
// (R11) Query command: 15 bytes, E4 13.
// (R12) Query reply F4 13, current group.
// (R13) Query reply check zero, trailer 12-15.
// (R14) Bad group or switch mode fails.
module ags_selector
  import ags_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       host_mode,
  input  wire logic       group_select_bit0,
  input  wire logic       group_select_bit1,
  input  wire logic       group_select_bit2,
  input  wire logic       group_select_bit3,
  input  wire logic [7:0] rx_data,
  input  wire logic       rx_valid,
  output logic            rx_ready,
  output logic      [7:0] tx_data,
  output logic            tx_valid,
  input  wire logic       tx_ready,
  output logic      [4:0] active_group,
  output logic            cmd_error
);
  typedef enum logic [1:0] {
    AGS_RX   = 2'b00,
    AGS_EXEC = 2'b01,
    AGS_TX   = 2'b10
  } ags_state_e;

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  logic [4:0] sync1, sync2;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {host_mode, group_select_bit3, group_select_bit2,
                group_select_bit1, group_select_bit0};
      sync2 <= sync1;
    end
  end

  // ==========================================================================
  // Receive, execute and reply sequencer
  // ==========================================================================
  ags_state_e state, next_state;
  logic [4:0] idx, next_idx;
  logic [7:0] main_b, next_main_b;
  logic [7:0] sub_b, next_sub_b;
  logic       next_rx_ready;
  logic [7:0] data_b, next_data_b;
  logic [7:0] reply, next_reply;
  logic       bad, next_bad;
  logic       is_rply_set, next_is_rply_set;
  logic [4:0] host_group, next_host_group;
  logic [4:0] next_active;
  logic       next_err;
  logic [7:0] exp_b;
  logic [7:0] f_data;
  logic       f_valid, f_ready, f_in_ready;
  logic [7:0] tx_byte;
  logic       tx_push;
  logic       rx_take;
  logic       is_qry;
  logic [4:0] last_idx;

  assign rx_take = rx_valid && rx_ready;
  assign is_qry  = (main_b == MAIN_QRY);
  assign last_idx = (is_qry ? QRY_LEN : SET_LEN) - 5'h01;

  // Expected fixed byte for the current receive position.
  always_comb begin
    exp_b = rx_data;
    if (idx == 5'h00 || idx == 5'h03) exp_b = HDR0; // R5
    else if (idx == 5'h01 || idx == 5'h02) exp_b = HDR1; // R5
    else if (idx >= 5'h06 && idx < POS_LEN_LO) exp_b = 8'h00; // R6
    else if (idx == POS_LEN_LO) exp_b = {3'h0, is_qry ? QRY_LEN : SET_LEN}; // R6
    else if (idx > last_idx - 5'h04) begin
      exp_b = (idx == last_idx - 5'h03 || idx == last_idx) ? TRL0 : TRL1; // R5
    end else if (idx == last_idx - 5'h04) exp_b = CHECK_BYTE; // R7 R11
  end

  // Reply byte for the current transmit position.
  always_comb begin
    case (idx)
      5'h00, 5'h03: tx_byte = HDR0; // R5
      5'h01, 5'h02: tx_byte = HDR1; // R5
      POS_MAIN:     tx_byte = is_rply_set ? MAIN_SET_RP : MAIN_QRY_RP; // R9 R12
      POS_SUB:      tx_byte = SUB_GROUP; // R9 R12
      POS_LEN_LO:   tx_byte = {3'h0, REPLY_LEN}; // R6
      POS_DATA:     tx_byte = reply; // R9 R12
      5'h0B:        tx_byte = CHECK_BYTE; // R10 R13
      5'h0C, 5'h0F: tx_byte = TRL0; // R10 R13
      5'h0D, 5'h0E: tx_byte = TRL1; // R10 R13
      default:      tx_byte = 8'h00; // R6
    endcase
  end

  assign tx_push = (state == AGS_TX) && f_in_ready;

  always_comb begin
    next_state       = state;
    next_idx         = idx;
    next_main_b      = main_b;
    next_sub_b       = sub_b;
    next_data_b      = data_b;
    next_reply       = reply;
    next_bad         = bad;
    next_is_rply_set = is_rply_set;
    next_host_group  = host_group;
    next_err         = 1'b0;
    next_active      = sync2[4] ? host_group : 5'({1'b0, sync2[3:0]} + 5'h01); // R1 R2 R3 R4
    case (state)
      AGS_RX: begin
        if (rx_take) begin
          if (idx == POS_MAIN) next_main_b = rx_data;
          if (idx == POS_SUB) next_sub_b = rx_data;
          if (idx == POS_DATA && !is_qry) next_data_b = rx_data;
          if (idx == POS_MAIN && rx_data != MAIN_SET && rx_data != MAIN_QRY) next_bad = 1'b1;
          if (idx > POS_SUB && rx_data != exp_b) next_bad = 1'b1;
          if (idx < POS_MAIN && rx_data != exp_b) begin
            // Resynchronise on a broken header.
            next_idx = (rx_data == HDR0) ? 5'h01 : 5'h00; // R5
          end else if (idx > POS_SUB && idx == last_idx) begin
            next_state = AGS_EXEC;
            next_idx   = 5'h00;
          end else begin
            next_idx = 5'(idx + 5'h01);
          end
        end
      end
      AGS_EXEC: begin
        next_state = AGS_RX;
        next_bad   = 1'b0;
        if (bad || sub_b != SUB_GROUP) begin
          next_err = 1'b1;
        end else if (is_qry) begin
          next_is_rply_set = 1'b0;
          next_reply       = {3'h0, active_group}; // R12
          next_state       = AGS_TX;
        end else begin
          next_is_rply_set = 1'b1;
          next_state       = AGS_TX; // R8
          if (sync2[4] && data_b >= 8'h01 && data_b <= {3'h0, GROUP_MAX}) begin
            next_host_group = data_b[4:0]; // R7
            next_reply      = ST_OK; // R9
          end else begin
            next_reply = ST_FAIL; // R14
          end
        end
      end
      AGS_TX: begin
        if (tx_push) begin
          next_idx = 5'(idx + 5'h01);
          if (idx == REPLY_LEN - 5'h01) begin
            next_state = AGS_RX;
            next_idx   = 5'h00;
          end
        end
      end
      default: next_state = AGS_RX;
    endcase
    next_rx_ready = (next_state == AGS_RX);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state        <= AGS_RX;
      idx          <= '0;
      main_b       <= '0;
      sub_b        <= '0;
      data_b       <= '0;
      reply        <= '0;
      bad          <= 1'b0;
      is_rply_set  <= 1'b0;
      host_group   <= GROUP_RST;
      active_group <= GROUP_RST;
      cmd_error    <= 1'b0;
      rx_ready     <= 1'b0;
    end else begin
      state        <= next_state;
      idx          <= next_idx;
      main_b       <= next_main_b;
      sub_b        <= next_sub_b;
      data_b       <= next_data_b;
      reply        <= next_reply;
      bad          <= next_bad;
      is_rply_set  <= next_is_rply_set;
      host_group   <= next_host_group;
      active_group <= next_active;
      cmd_error    <= next_err;
      rx_ready     <= next_rx_ready;
    end
  end

  // ==========================================================================
  // Reply buffer
  // ==========================================================================
  ags_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .in_data   (tx_byte),
    .in_valid  (state == AGS_TX),
    .in_ready  (f_in_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_ready)
  );

  // Output stage keeps tx_data and tx_valid registered.
  logic       next_tx_valid;
  logic [7:0] next_tx_data;
  assign f_ready       = !tx_valid || tx_ready;
  assign next_tx_valid = f_ready ? f_valid : tx_valid;
  assign next_tx_data  = (f_ready && f_valid) ? f_data : tx_data;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tx_valid <= 1'b0;
      tx_data  <= '0;
    end else begin
      tx_valid <= next_tx_valid;
      tx_data  <= next_tx_data;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_sw_group;
    @(posedge sys_clk) disable iff (!rstn)
    !sync2[4] |=> active_group == 5'($past(sync2[3:0]) + 5'h01);
  endproperty
  a_sw_group: assert property (p_sw_group) else $error("switch group wrong"); // R4

  property p_range;
    @(posedge sys_clk) disable iff (!rstn)
    active_group >= 5'h01 && active_group <= GROUP_MAX;
  endproperty
  a_range: assert property (p_range) else $error("group out of range"); // R3

  property p_fail;
    @(posedge sys_clk) disable iff (!rstn)
    state == AGS_EXEC && !bad && sub_b == SUB_GROUP && !is_qry && !sync2[4]
      |=> reply == ST_FAIL && $stable(host_group);
  endproperty
  a_fail: assert property (p_fail) else $error("set in switch mode not refused"); // R14

  property p_answer;
    @(posedge sys_clk) disable iff (!rstn)
    state == AGS_EXEC && !bad && sub_b == SUB_GROUP |=> state == AGS_TX;
  endproperty
  a_answer: assert property (p_answer) else $error("command not answered"); // R8

  property p_hdr;
    @(posedge sys_clk) disable iff (!rstn)
    tx_push && idx == 5'h00 |-> tx_byte == HDR0;
  endproperty
  a_hdr: assert property (p_hdr) else $error("bad reply header"); // R5

  property p_len;
    @(posedge sys_clk) disable iff (!rstn)
    tx_push && idx == POS_LEN_LO |-> tx_byte == 8'h10;
  endproperty
  a_len: assert property (p_len) else $error("bad reply length"); // R6

  property p_qry;
    @(posedge sys_clk) disable iff (!rstn)
    tx_push && idx == POS_DATA && !is_rply_set |-> tx_byte == {3'h0, active_group};
  endproperty
  a_qry: assert property (p_qry) else $error("query reply group wrong"); // R12

  property p_main;
    @(posedge sys_clk) disable iff (!rstn)
    tx_push && idx == POS_MAIN |-> tx_byte == (is_rply_set ? 8'hF3 : 8'hF4);
  endproperty
  a_main: assert property (p_main) else $error("reply main code wrong"); // R9

  property p_tail;
    @(posedge sys_clk) disable iff (!rstn)
    tx_push && idx == 5'h0B |-> tx_byte == 8'h00;
  endproperty
  a_tail: assert property (p_tail) else $error("reply check byte not zero"); // R10 R13
endmodule : ags_selector

// ===== ags_pkg.sv
package ags_pkg;
  // ==========================================================================
  // Frame layout
  // ==========================================================================
  localparam logic [7:0]  HDR0        = 8'hAA;
  localparam logic [7:0]  HDR1        = 8'h88;
  localparam logic [7:0]  TRL0        = 8'h88;
  localparam logic [7:0]  TRL1        = 8'hAA;
  localparam logic [7:0]  MAIN_SET    = 8'hE3;
  localparam logic [7:0]  MAIN_QRY    = 8'hE4;
  localparam logic [7:0]  MAIN_SET_RP = 8'hF3;
  localparam logic [7:0]  MAIN_QRY_RP = 8'hF4;
  localparam logic [7:0]  SUB_GROUP   = 8'h13;
  localparam logic [7:0]  ST_OK       = 8'h00;
  localparam logic [7:0]  ST_FAIL     = 8'h01;
  localparam logic [7:0]  CHECK_BYTE  = 8'h00;
  localparam logic [4:0]  SET_LEN     = 5'h10;
  localparam logic [4:0]  QRY_LEN     = 5'h0F;
  localparam logic [4:0]  REPLY_LEN   = 5'h10;
  localparam logic [4:0]  POS_MAIN    = 5'h04;
  localparam logic [4:0]  POS_SUB     = 5'h05;
  localparam logic [4:0]  POS_LEN_LO  = 5'h09;
  localparam logic [4:0]  POS_DATA    = 5'h0A;
  localparam logic [4:0]  GROUP_MAX   = 5'h10;
  localparam logic [4:0]  GROUP_RST   = 5'h01;
  localparam int          FIFO_W      = 8;
  localparam int          FIFO_D      = 8;
endpackage : ags_pkg

// ===== ags_fifo.sv
module ags_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic      [W-1:0] out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp, rp, next_wp, next_rp;
  logic [AW:0]   cnt, next_cnt;
  logic          wr, rd;
  logic          next_in_ready, next_out_valid;

  always_comb begin
    wr       = in_valid && in_ready;
    rd       = out_valid && out_ready;
    next_wp  = wr ? AW'(wp + 1'b1) : wp;
    next_rp  = rd ? AW'(rp + 1'b1) : rp;
    next_cnt = (AW+1)'(cnt + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd});
    next_in_ready  = next_cnt < (AW+1)'(D);
    next_out_valid = next_cnt != '0;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wp        <= '0;
      rp        <= '0;
      cnt       <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      wp        <= next_wp;
      rp        <= next_rp;
      cnt       <= next_cnt;
      in_ready  <= next_in_ready;
      out_valid <= next_out_valid;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (wr) begin
      mem[wp] <= in_data;
    end
  end

  assign out_data = mem[rp];
endmodule : ags_fifo

// ===== ags_host_model.sv
// ==========================================================================
// Host side of the command link
// ==========================================================================
module ags_host_model (
  input  wire logic       sys_clk,
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] frame [16];
  logic       slow;

  initial begin
    rx_data  = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
    slow     = 1'b0;
  end

  // Sends a set frame (len 10h) or a query frame (len 0Fh).
  task automatic send(input logic [7:0] main, input logic [4:0] len,
                      input logic [7:0] grp, input logic [7:0] chk);
    int p;
    frame[0] = 8'hAA;
    frame[1] = 8'h88;
    frame[2] = 8'h88;
    frame[3] = 8'hAA;
    frame[4] = main;
    frame[5] = 8'h13;
    frame[6] = 8'h00;
    frame[7] = 8'h00;
    frame[8] = 8'h00;
    frame[9] = {3'h0, len};
    p = 10;
    if (len == 5'h10) begin
      frame[10] = grp;
      p = 11;
    end
    frame[p]   = chk;
    frame[p+1] = 8'h88;
    frame[p+2] = 8'hAA;
    frame[p+3] = 8'hAA;
    frame[p+4] = 8'h88;
    for (int i = 0; i < int'(len); i++) begin
      rx_valid <= 1'b1;
      rx_data  <= frame[i];
      do @(posedge sys_clk); while (rx_ready !== 1'b1);
    end
    // Released data never keeps showing the last byte.
    rx_valid <= 1'b0;
    rx_data  <= ~frame[int'(len) - 1];
  endtask : send

  // Collects one 16-byte reply; a slow host stalls every other cycle.
  task automatic recv(output logic [7:0] r [16]);
    int n;
    n = 0;
    while (n < 16) begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
      @(posedge sys_clk);
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
        r[n] = tx_data;
        n++;
      end
    end
    tx_ready <= 1'b0;
  endtask : recv
endmodule : ags_host_model

// ===== test_area_group_selector.sv
module test_area_group_selector;
  timeunit 1ns;
  timeprecision 1ps;

  logic       sys_clk;
  logic       rstn;
  logic       host_mode;
  logic [3:0] sw;
  logic [7:0] rx_data;
  logic       rx_valid;
  logic       rx_ready;
  logic [7:0] tx_data;
  logic       tx_valid;
  logic       tx_ready;
  logic [4:0] active_group;
  logic       cmd_error;
  int         miscompares;
  int         total_checks;
  int         error_pulses;

  ags_selector ags_selector_i (
    .sys_clk(sys_clk), .rstn(rstn), .host_mode(host_mode),
    .group_select_bit0(sw[0]), .group_select_bit1(sw[1]),
    .group_select_bit2(sw[2]), .group_select_bit3(sw[3]),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .active_group(active_group), .cmd_error(cmd_error)
  );

  ags_host_model ags_host_model_i (
    .sys_clk(sys_clk), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready)
  );

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (cmd_error === 1'b1) begin
      error_pulses <= error_pulses + 1;
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic reply(input logic [7:0] main, input logic [7:0] data);
    logic [7:0] r [16];
    logic [7:0] e [16];
    e = '{8'hAA, 8'h88, 8'h88, 8'hAA, main, 8'h13, 8'h00, 8'h00, 8'h00, 8'h10,
          data, 8'h00, 8'h88, 8'hAA, 8'hAA, 8'h88};
    ags_host_model_i.recv(r);
    for (int i = 0; i < 16; i++) begin
      check($sformatf("reply byte %0d", i), r[i], e[i]);
    end
  endtask : reply

  task automatic check_group(input logic [4:0] exp);
    repeat (2) @(posedge sys_clk);
    check("active group", {3'h0, active_group}, {3'h0, exp});
  endtask : check_group

  task automatic test_switches();
    for (int v = 0; v < 16; v++) begin
      sw <= 4'(v);
      repeat (4) @(posedge sys_clk);
      check_group(5'(v + 1));
    end
    $display("test switches done");
  endtask : test_switches

  task automatic test_set_in_switch_mode();
    sw <= 4'h5;
    repeat (6) @(posedge sys_clk);
    ags_host_model_i.send(8'hE3, 5'h10, 8'h03, 8'h00);
    @(posedge sys_clk);
    check("rx ready while busy", {7'h0, rx_ready}, 8'h00);
    reply(8'hF3, 8'h01);
    check_group(5'h06);
    $display("test set in switch mode done");
  endtask : test_set_in_switch_mode

  task automatic test_host_set_query();
    host_mode <= 1'b1;
    repeat (6) @(posedge sys_clk);
    ags_host_model_i.send(8'hE3, 5'h10, 8'h10, 8'h00);
    reply(8'hF3, 8'h00);
    check_group(5'h10);
    sw <= 4'h9;
    repeat (6) @(posedge sys_clk);
    ags_host_model_i.send(8'hE4, 5'h0F, 8'h00, 8'h00);
    reply(8'hF4, 8'h10);
    $display("test host set and query done");
  endtask : test_host_set_query

  task automatic test_out_of_range();
    ags_host_model_i.send(8'hE3, 5'h10, 8'h00, 8'h00);
    reply(8'hF3, 8'h01);
    ags_host_model_i.send(8'hE3, 5'h10, 8'h11, 8'h00);
    reply(8'hF3, 8'h01);
    check_group(5'h10);
    ags_host_model_i.send(8'hE3, 5'h10, 8'h01, 8'h00);
    reply(8'hF3, 8'h00);
    ags_host_model_i.slow = 1'b1;
    ags_host_model_i.send(8'hE4, 5'h0F, 8'h00, 8'h00);
    reply(8'hF4, 8'h01);
    ags_host_model_i.slow = 1'b0;
    $display("test out of range done");
  endtask : test_out_of_range

  task automatic test_malformed();
    int   n;
    logic seen_tx;
    n = error_pulses;
    seen_tx = 1'b0;
    ags_host_model_i.send(8'hE3, 5'h10, 8'h05, 8'h55);
    repeat (20) begin
      @(posedge sys_clk);
      if (tx_valid === 1'b1) seen_tx = 1'b1;
    end
    check("error pulses", 8'(error_pulses - n), 8'h01);
    check("stray reply", {7'h0, seen_tx}, 8'h00);
    check_group(5'h01);
    ags_host_model_i.send(8'hE4, 5'h0F, 8'h00, 8'h00);
    reply(8'hF4, 8'h01);
    $display("test malformed done");
  endtask : test_malformed

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  initial begin
    rstn = 1'b0;
    host_mode = 1'b0;
    sw = 4'h0;
    miscompares = 0;
    total_checks = 0;
    error_pulses = 0;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    test_switches();
    test_set_in_switch_mode();
    test_host_set_query();
    test_out_of_range();
    test_malformed();
    finish_test();
  end

  // Whole run needs well under 2000 cycles.
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    finish_test();
  end
endmodule : test_area_group_selector
